// *** hdl/pksv_pkg.sv ***
// Package with register map, field positions, command codes and types
package pksv_pkg;
  // Register byte addresses
  localparam logic [31:0] PKSV_STATUS_ADDR  = 32'h5000600c;
  localparam logic [31:0] PKSV_VERSION_ADDR = 32'h50006010;
  // Status field positions
  localparam int PKSV_BUSY_BIT   = 16;
  localparam int PKSV_PRIME_BIT  = 12;
  localparam int PKSV_NINV_BIT   = 11;
  localparam int PKSV_COEF_BIT   = 10;
  localparam int PKSV_SIG_BIT    = 9;
  localparam int PKSV_ORDER_BIT  = 7;
  localparam int PKSV_COORD_BIT  = 6;
  localparam int PKSV_INF_BIT    = 5;
  localparam int PKSV_OFFC_BIT   = 4;
  localparam int PKSV_ADDR_W     = 4;
  localparam logic [31:0] PKSV_STATUS_RESET = 32'h0;
  // Operation code groups [6:4] and low codes [3:0]
  localparam logic [2:0] PKSV_GRP_PRIM = 3'h0;
  localparam logic [2:0] PKSV_GRP_ECC  = 3'h2;
  localparam logic [2:0] PKSV_GRP_HIGH = 3'h3;
  localparam logic [3:0] PKSV_OP_INV_ODD  = 4'h6;
  localparam logic [3:0] PKSV_OP_INV_EVEN = 4'h9;
  localparam logic [3:0] PKSV_OP_COEFFICIENT_CHECK_COMMAND = 4'h3;
  localparam logic [3:0] PKSV_OP_CHECK_N  = 4'h4;
  localparam logic [3:0] PKSV_OP_CHECK_XY = 4'h5;
  localparam logic [3:0] PKSV_OP_ON_CURVE = 4'h6;
  // Version register defaults; hardware value is arbitrary
  localparam logic [7:0] PKSV_HW_VERSION_DEF   = 8'h5a;
  localparam logic [7:0] PKSV_CODE_VERSION_DEF = 8'h00;

  // Completion report from the arithmetic core
  typedef struct packed {
    logic       prime_composite;
    logic       not_invertible;
    logic       coef_invalid;
    logic       sig_invalid;
    logic       order_invalid;
    logic       coord_invalid;
    logic       at_infinity;
    logic       off_curve;
    logic [3:0] fail_addr;
    logic       fail_addr_valid;
    logic       is_ecc_op;
    logic       is_sig_op;
    logic       is_prime_test;
  } pksv_result_s;

  typedef enum logic [1:0] {
    PKSV_IDLE = 2'b01,
    PKSV_BUSY = 2'b10
  } pksv_state_e;
endpackage

// *** hdl/pksv_flag_cell.sv ***
// One sticky result flag updated only by the command that owns it
`timescale 1ns/100ps
module pksv_flag_cell (
  input  wire logic CLOCK,
  input  wire logic SRST,
  input  wire logic UPDATE,
  input  wire logic VALUE,
  output logic      FLAG
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (UPDATE) begin
      flag_next = VALUE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign FLAG = flag_reg;
endmodule // pksv_flag_cell

// *** hdl/pksv_status_version.sv ***
// Status and version registers of the public-key engine
`timescale 1ns/100ps
// Function
// - Busy bit 16 high while command runs, low when algorithm completes.
// - Primality bit 12: 0 probably prime, 1 composite, after primality test.
// - Inversion ops 0x6 or 0x9 on non-invertible operand set bit 11.
// - Coefficient check sets bit 10 if a,b invalid, else clears it.
// - Signature commands update bit 9; 1 means reject signature.
// - Order check sets bit 7 when parameter n invalid.
// - Coordinate check sets bit 6 when x or y not below prime.
// - Every curve operation updates bit 5, infinity result sets it.
// - Point-on-curve check sets bit 4 when point off curve.
// - Bits 3:0 hold address of last failing or infinite point.
// - Version register bits 15:8 give read-only hardware version.
// - Bits 7:0 read-only code version; corrupted after use, read first.
// - Start ignored while busy; start bit self-clears at finish.
module pksv_status_version
  import pksv_pkg::*;
#(
  parameter logic [7:0] HW_VERSION = PKSV_HW_VERSION_DEF
) (
  input  wire logic         CLOCK,
  input  wire logic         SRST,
  input  wire logic         START_BIT,
  input  wire logic [6:0]   OPERATION_CODE,
  input  wire logic         CORE_DONE,
  input  wire pksv_result_s CORE_RESULT,
  input  wire logic         CODE_VERSION_WE,
  input  wire logic [7:0]   CODE_VERSION_WDATA,
  input  wire logic         RD_EN,
  input  wire logic [31:0]  RD_ADDR,
  output logic [31:0]       RD_DATA,
  output logic              CORE_LAUNCH,
  output logic              START_CLEAR,
  output logic              BUSY
);
  pksv_state_e state_reg;
  pksv_state_e state_next;
  logic [6:0]  op_reg;
  logic [6:0]  op_next;
  logic        launch_reg;
  logic        launch_next;
  logic        clr_reg;
  logic        clr_next;
  logic [3:0]  addr_reg;
  logic [3:0]  addr_next;
  logic [7:0]  code_ver_reg;
  logic [7:0]  code_ver_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic [7:0]  upd;
  logic [7:0]  val;
  logic [7:0]  flags;
  logic        done;

  assign done = (state_reg == PKSV_BUSY) && CORE_DONE;

  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    launch_next = 1'b0;
    clr_next    = 1'b0;
    case (state_reg)
      PKSV_IDLE: begin
        // start clear cycle
        // The control bit is still high while its clear is in flight; taking it would relaunch
        if (START_BIT && !clr_reg) begin
          state_next  = PKSV_BUSY;
          op_next     = OPERATION_CODE;
          launch_next = 1'b1;
        end
      end
      PKSV_BUSY: begin
        // Start held high here is ignored; the core runs one command
        if (CORE_DONE) begin
          state_next = PKSV_IDLE;
          clr_next   = 1'b1;
        end
      end
      default: begin
        state_next = PKSV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_reg  <= PKSV_IDLE;
      op_reg     <= 7'h00;
      launch_reg <= 1'b0;
      clr_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      launch_reg <= launch_next;
      clr_reg    <= clr_next;
    end
  end

  // Update strobes per flag, ordered bit 12,11,10,9,7,6,5,4 -> index 7..0
  always_comb begin
    upd = 8'h00;
    val = 8'h00;
    upd[7] = done && CORE_RESULT.is_prime_test;
    val[7] = CORE_RESULT.prime_composite;
    upd[6] = done && (op_reg[6:4] == PKSV_GRP_PRIM)
             && ((op_reg[3:0] == PKSV_OP_INV_ODD) || (op_reg[3:0] == PKSV_OP_INV_EVEN));
    val[6] = CORE_RESULT.not_invertible;
    upd[5] = done && (op_reg[6:4] == PKSV_GRP_ECC) && (op_reg[3:0] == PKSV_OP_COEFFICIENT_CHECK_COMMAND);
    val[5] = CORE_RESULT.coef_invalid;
    upd[4] = done && CORE_RESULT.is_sig_op;
    val[4] = CORE_RESULT.sig_invalid;
    upd[3] = done && (op_reg[6:4] == PKSV_GRP_ECC) && (op_reg[3:0] == PKSV_OP_CHECK_N);
    val[3] = CORE_RESULT.order_invalid;
    upd[2] = done && (op_reg[6:4] == PKSV_GRP_ECC) && (op_reg[3:0] == PKSV_OP_CHECK_XY);
    val[2] = CORE_RESULT.coord_invalid;
    upd[1] = done && (CORE_RESULT.is_ecc_op || op_reg[6:4] == PKSV_GRP_ECC);
    val[1] = CORE_RESULT.at_infinity;
    upd[0] = done && (op_reg[6:4] == PKSV_GRP_ECC) && (op_reg[3:0] == PKSV_OP_ON_CURVE);
    val[0] = CORE_RESULT.off_curve;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      pksv_flag_cell u_flag (
        .CLOCK  (CLOCK),
        .SRST   (SRST),
        .UPDATE (upd[gi]),
        .VALUE  (val[gi]),
        .FLAG   (flags[gi])
      );
    end
  endgenerate

  // fail address, code version, read mux
  always_comb begin
    addr_next     = addr_reg;
    code_ver_next = code_ver_reg;
    rd_data_next  = rd_data_reg;
    if (done && CORE_RESULT.fail_addr_valid) begin
      addr_next = CORE_RESULT.fail_addr;
    end
    // Core microcode overwrites this byte once it runs
    if (CODE_VERSION_WE) begin
      code_ver_next = CODE_VERSION_WDATA;
    end
    if (RD_EN) begin
      rd_data_next = 32'h0;
      if (RD_ADDR == PKSV_STATUS_ADDR) begin
        rd_data_next[PKSV_BUSY_BIT]  = (state_reg == PKSV_BUSY);
        rd_data_next[PKSV_PRIME_BIT] = flags[7];
        rd_data_next[PKSV_NINV_BIT]  = flags[6];
        rd_data_next[PKSV_COEF_BIT]  = flags[5];
        rd_data_next[PKSV_SIG_BIT]   = flags[4];
        rd_data_next[PKSV_ORDER_BIT] = flags[3];
        rd_data_next[PKSV_COORD_BIT] = flags[2];
        rd_data_next[PKSV_INF_BIT]   = flags[1];
        rd_data_next[PKSV_OFFC_BIT]  = flags[0];
        rd_data_next[PKSV_ADDR_W-1:0] = addr_reg;
      end else if (RD_ADDR == PKSV_VERSION_ADDR) begin
        rd_data_next[15:8] = HW_VERSION;
        rd_data_next[7:0]  = code_ver_reg;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      addr_reg     <= 4'h0;
      code_ver_reg <= PKSV_CODE_VERSION_DEF;
      rd_data_reg  <= PKSV_STATUS_RESET;
    end else begin
      addr_reg     <= addr_next;
      code_ver_reg <= code_ver_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  assign RD_DATA     = rd_data_reg;
  assign CORE_LAUNCH = launch_reg;
  assign START_CLEAR = clr_reg;
  // One-hot busy code bit, taken straight from the state flop
  assign BUSY        = state_reg[1];
endmodule // pksv_status_version

// *** dv/pksv_status_version_properties.sv ***
// Port timing checker for the status and version block
`timescale 1ns/100ps
module pksv_status_version_properties
  import pksv_pkg::*;
#(parameter logic [7:0] HW_VERSION = PKSV_HW_VERSION_DEF) (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        START_BIT,
  input wire logic        CORE_DONE,
  input wire logic        RD_EN,
  input wire logic [31:0] RD_ADDR,
  input wire logic [31:0] RD_DATA,
  input wire logic        CORE_LAUNCH,
  input wire logic        START_CLEAR,
  input wire logic        BUSY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  launch_on_start_a: assert property (START_BIT && !BUSY && !START_CLEAR |=> BUSY && CORE_LAUNCH)
    else $error("no launch");
  clear_no_relaunch_a: assert property (START_CLEAR |=> !CORE_LAUNCH)
    else $error("relaunch in clear cycle");
  busy_hold_a: assert property (BUSY && !CORE_DONE |=> BUSY)
    else $error("busy dropped early");
  busy_fall_a: assert property (BUSY && CORE_DONE |=> !BUSY && START_CLEAR)
    else $error("busy not ended");
  start_ignored_a: assert property (BUSY && START_BIT |=> !CORE_LAUNCH)
    else $error("relaunch while busy");
  clear_moment_a: assert property (START_CLEAR |-> $past(BUSY) && !BUSY)
    else $error("stray start clear");
  read_busy_a: assert property (RD_EN && RD_ADDR == PKSV_STATUS_ADDR
    |=> RD_DATA[16] == $past(BUSY) && RD_DATA[31:17] == 15'h0) else $error("busy bit");
  hw_version_a: assert property (RD_EN && RD_ADDR == PKSV_VERSION_ADDR
    |=> RD_DATA[31:8] == {16'h0, HW_VERSION}) else $error("hw version");
  read_hold_a: assert property (!RD_EN |=> $stable(RD_DATA))
    else $error("read data moved");
endmodule // pksv_status_version_properties

bind pksv_status_version pksv_status_version_properties #(.HW_VERSION(HW_VERSION)) chk_u (
  .CLOCK(CLOCK), .SRST(SRST), .START_BIT(START_BIT), .CORE_DONE(CORE_DONE),
  .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .CORE_LAUNCH(CORE_LAUNCH),
  .START_CLEAR(START_CLEAR), .BUSY(BUSY));

// *** dv/pksv_core_model.sv ***
// Behavioural arithmetic core answering each launch after a set latency
`timescale 1ns/100ps
module pksv_core_model
  import pksv_pkg::*;
(
  input  wire logic         CLOCK,
  input  wire logic         SRST,
  input  wire logic         CORE_LAUNCH,
  input  wire logic [7:0]   LATENCY,
  input  wire pksv_result_s RESULT_IN,
  output logic              CORE_DONE,
  output pksv_result_s      CORE_RESULT
);
  logic [7:0] cnt_reg;
  always_ff @(posedge CLOCK) begin
    if (SRST) cnt_reg <= 8'h00;
    else if (CORE_LAUNCH) cnt_reg <= LATENCY;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  assign CORE_DONE = (cnt_reg == 8'h01);
  // Result only means something with done; garble it otherwise
  assign CORE_RESULT = CORE_DONE ? RESULT_IN : pksv_result_s'(~RESULT_IN);
endmodule // pksv_core_model

// *** dv/tb_top.sv ***
// Self-checking bench for the status and version block
`timescale 1ns/100ps
module tb_top;
  import pksv_pkg::*;
  logic clock = 1'b0, srst = 1'b1, start_bit = 1'b0, cv_we = 1'b0, rd_en = 1'b0;
  logic         core_done, core_launch, start_clear, busy;
  logic [6:0]   op_code = 7'h00;
  logic [7:0]   lat_in = 8'h01, cv_wdata = 8'h00;
  logic [31:0]  rd_addr = 32'h0, rd_data, d;
  pksv_result_s core_result, res_in = '0;
  int           errors = 0, checks_done = 0, cyc = 0;
  // Opcode, core result, expected status; flags accumulate row to row
  logic [54:0]  rows [10] = '{{7'h03, 16'h8001, 32'h1000}, {7'h06, 16'h4000, 32'h1800},
    {7'h09, 16'h0000, 32'h1000}, {7'h23, 16'h2000, 32'h1400}, {7'h32, 16'h1002, 32'h1600},
    {7'h24, 16'h0800, 32'h1680}, {7'h25, 16'h0400, 32'h16c0}, {7'h26, 16'h0138, 32'h16d3},
    {7'h20, 16'h025c, 32'h16f5}, {7'h01, 16'h2001, 32'h06f5}};
  always #2.5 clock = ~clock;
  pksv_status_version #(.HW_VERSION(8'hc3)) dut_u (.CLOCK(clock), .SRST(srst),
    .START_BIT(start_bit), .OPERATION_CODE(op_code), .CORE_DONE(core_done),
    .CORE_RESULT(core_result), .CODE_VERSION_WE(cv_we), .CODE_VERSION_WDATA(cv_wdata),
    .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .CORE_LAUNCH(core_launch),
    .START_CLEAR(start_clear), .BUSY(busy));
  pksv_core_model core_u (.CLOCK(clock), .SRST(srst), .CORE_LAUNCH(core_launch),
    .LATENCY(lat_in), .RESULT_IN(res_in), .CORE_DONE(core_done), .CORE_RESULT(core_result));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [31:0] a);
    @(negedge clock);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    d = rd_data;
  endtask
  task automatic cmd(input logic [6:0] op, input logic [15:0] r, input logic [7:0] lat);
    @(negedge clock);
    op_code = op;
    res_in = r;
    lat_in = lat;
    start_bit = 1'b1;
  endtask
  // Start stays high until the block clears it, like the control register
  // The register drops the bit only at the edge that samples the clear pulse
  task automatic fin;
    while (start_clear !== 1'b1) @(negedge clock);
    @(negedge clock);
    start_bit = 1'b0;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    srst = 1'b0;
    rd(PKSV_STATUS_ADDR);
    chk("status", 32'h0, d);
    rd(PKSV_VERSION_ADDR);
    chk("version", 32'hc300, d);
    foreach (rows[i]) begin
      cmd(rows[i][54:48], rows[i][47:32], 8'(i + 1));
      fin();
      rd(PKSV_STATUS_ADDR);
      chk("status", rows[i][31:0], d);
    end
    cmd(7'h10, 16'hfff0, 8'h14);
    rd(PKSV_STATUS_ADDR);
    chk("status", 32'h106f5, d);
    fin();
    rd(PKSV_STATUS_ADDR);
    chk("status", 32'h6f5, d);
    rd(32'h50006000);
    chk("unmapped", 32'h0, d);
    @(negedge clock);
    cv_we = 1'b1;
    cv_wdata = 8'h7e;
    @(negedge clock);
    cv_we = 1'b0;
    rd(PKSV_VERSION_ADDR);
    chk("version", 32'hc37e, d);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    rd(PKSV_STATUS_ADDR);
    chk("status", 32'h0, d);
    report_and_stop();
  end
endmodule // tb_top
